// >>> logic/fllc_pkg.sv
// constants and types shared by the loop clock generator control
package fllc_pkg;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam int REG_W = 16;
    localparam int ADDR_W = 10;
    localparam int IDX_W = 8;
    localparam int LANE_W = 2;
    localparam logic [LANE_W-1:0] LANE_ZERO = 2'h0;

    // register indices, byte address is index times four
    localparam logic [IDX_W-1:0] IDX_ENABLE = 8'h3C;
    localparam logic [IDX_W-1:0] IDX_DIVIDER = 8'h3D;
    localparam logic [IDX_W-1:0] IDX_FRACTION = 8'h3E;
    localparam logic [IDX_W-1:0] IDX_INTEGER = 8'h3F;
    localparam logic [IDX_W-1:0] IDX_REFERENCE = 8'h40;
    localparam logic [IDX_W-1:0] IDX_STATUS = 8'h50;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int LOOP_ENABLE_BIT = 0;
    localparam int OSC_ENABLE_BIT = 1;
    localparam int FRACTIONAL_BIT = 2;
    localparam int OUTDIV_LSB = 8;
    localparam int OUTDIV_W = 3;
    localparam int FRATIO_LSB = 0;
    localparam int FRATIO_W = 3;
    localparam int INTMUL_LSB = 5;
    localparam int INTMUL_W = 10;
    localparam int FORCE_VAL_LSB = 7;
    localparam int FORCE_VAL_W = 6;
    localparam int FORCE_SEL_BIT = 6;
    localparam int REFDIV_LSB = 3;
    localparam int REFDIV_W = 2;
    localparam int SRC_LSB = 0;
    localparam int SRC_W = 2;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_LOCK_BIT = 1;
    localparam int STAT_FREE_BIT = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [INTMUL_W-1:0] INTMUL_RESET = 10'h177;
    localparam logic [SRC_W-1:0] SRC_RESET = 2'h2;

    // reference source codes
    localparam logic [SRC_W-1:0] SRC_MASTER = 2'h0;
    localparam logic [SRC_W-1:0] SRC_FRAME = 2'h1;
    localparam logic [SRC_W-1:0] SRC_BIT = 2'h2;

    // ------------------------------------------------------------
    // oscillator model
    // ------------------------------------------------------------
    localparam int CTL_W = 16;
    localparam int FB_DIV_W = 4;
    localparam int OUT_CNT_W = 7;

    typedef enum logic [2:0] {
        FLLC_OFF = 3'b001,
        FLLC_FREE = 3'b010,
        FLLC_TRACK = 3'b100
    } fllc_mode_t;

endpackage : fllc_pkg

// >>> logic/fllc_ref_div.sv
// reference selection, edge detection and power-of-two pre-divider
`timescale 1ns/10ps
module fllc_ref_div
    import fllc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [SRC_W-1:0] src_sel,
    input wire logic [REFDIV_W-1:0] div_sel,
    input wire logic master_clk_in,
    input wire logic frame_clk_in,
    input wire logic bit_clk_in,
    output logic ref_tick
);

    typedef struct packed {
        logic level;
        logic [2:0] cnt;
        logic tick;
    } fllc_refdiv_state_t;

    fllc_refdiv_state_t q;
    fllc_refdiv_state_t d;
    logic sel_level;
    logic [2:0] mask;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        // [RULE_11] reference source choice
        unique case (src_sel)
            SRC_MASTER: sel_level = master_clk_in;
            SRC_FRAME: sel_level = frame_clk_in;
            SRC_BIT: sel_level = bit_clk_in;
            default: sel_level = 1'b0;
        endcase
        // [RULE_09] divide by 1, 2, 4 or 8
        unique case (div_sel)
            2'h0: mask = 3'h0;
            2'h1: mask = 3'h1;
            2'h2: mask = 3'h3;
            default: mask = 3'h7;
        endcase
        d.level = sel_level;
        if (!enable) begin
            d.cnt = 3'h0;
        end else if (sel_level && !q.level) begin
            d.cnt = q.cnt + 3'h1;
            d.tick = ((q.cnt & mask) == mask);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ref_tick = q.tick;

endmodule : fllc_ref_div

// >>> logic/fllc_osc.sv
// numerically controlled oscillator standing in for the analogue one
`timescale 1ns/10ps
module fllc_osc
    import fllc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [CTL_W-1:0] ctl,
    output logic osc_tick
);

    typedef struct packed {
        logic [CTL_W-1:0] acc;
        logic tick;
    } fllc_osc_state_t;

    fllc_osc_state_t q;
    fllc_osc_state_t d;
    logic [CTL_W:0] sum;

    always_comb begin
        sum = {1'b0, q.acc} + {1'b0, ctl};
        d = q;
        if (run) begin
            d.acc = sum[CTL_W-1:0];
            d.tick = sum[CTL_W];
        end else begin
            d.acc = '0;
            d.tick = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign osc_tick = q.tick;

endmodule : fllc_osc

// >>> logic/fllc_control.sv
// What this block does
// [RULE_01] The loop runs only while loop enable is set; oscillator enable matters only for free running.
// [RULE_02] Software should always set fractional mode, bit 2, to one.
// [RULE_03] The oscillator is divided by 2 up to 256 by the output divider in bits 10:8.
// [RULE_04] Feedback ratio in bits 2:0 divides by 1, 2, 4, 8, or 16 when its top bit is set.
// [RULE_05] A 16-bit fraction multiplier scales the reference, its top bit weighing one half.
// [RULE_06] A 10-bit integer multiplier in bits 14:5 scales the reference, LSB weighing one.
// [RULE_07] Control select bit 6 picks the digital loop at zero or the forced value at one.
// [RULE_08] A 6-bit forced oscillator value in bits 12:7 drives the oscillator when forced.
// [RULE_09] The chosen reference is divided by 1, 2, 4 or 8 by the field in bits 4:3.
// [RULE_10] Software keeps the divided reference at or below 13.5 MHz.
// [RULE_11] Reference source in bits 1:0: master 00, frame 01, bit clock 10 at reset, 11 reserved.
// [RULE_12] Software avoids the reserved source and changes settings only with the loop off.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
module fllc_control
    import fllc_pkg::*;
#(
    parameter logic [CTL_W-1:0] LOOP_STEP = 16'h0010
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [REG_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [REG_W-1:0] reg_rdata,
    input wire logic master_clk_in,
    input wire logic frame_clk_in,
    input wire logic bit_clk_in,
    output logic loop_output_clk,
    output logic loop_running,
    output logic loop_locked
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic loop_enable;
        logic oscillator_enable;
        logic fractional_mode;
        logic [OUTDIV_W-1:0] output_divider;
        logic [FRATIO_W-1:0] feedback_ratio;
        logic [REG_W-1:0] fraction_multiplier;
        logic [INTMUL_W-1:0] integer_multiplier;
        logic [FORCE_VAL_W-1:0] forced_oscillator_value;
        logic force_oscillator_select;
        logic [REFDIV_W-1:0] reference_divider;
        logic [SRC_W-1:0] reference_source_select;
        logic [REG_W-1:0] rdata;
        fllc_mode_t mode;
        logic [CTL_W-1:0] ctl;
        logic [FB_DIV_W-1:0] fb_div;
        logic [REG_W-1:0] fb_cnt;
        logic [REG_W-1:0] frac_acc;
        logic [OUT_CNT_W-1:0] out_cnt;
        logic out_clk;
        logic running;
        logic locked;
    } fllc_state_t;

    fllc_state_t q;
    fllc_state_t d;
    logic ref_tick;
    logic osc_tick;
    logic hit;
    logic [IDX_W-1:0] idx;
    logic [FB_DIV_W-1:0] fb_mask;
    logic fb_tick;
    logic [REG_W:0] frac_sum;
    logic [REG_W-1:0] target;
    logic [REG_W-1:0] fb_total;
    logic [OUT_CNT_W-1:0] out_half;
    logic [CTL_W:0] ctl_up;

    // ------------------------------------------------------------
    // reference path and oscillator
    // ------------------------------------------------------------
    fllc_ref_div u_ref_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable(q.mode == FLLC_TRACK),
        .src_sel(q.reference_source_select),
        .div_sel(q.reference_divider),
        .master_clk_in(master_clk_in),
        .frame_clk_in(frame_clk_in),
        .bit_clk_in(bit_clk_in),
        .ref_tick(ref_tick)
    );

    fllc_osc u_osc (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(q.mode != FLLC_OFF),
        .ctl(q.ctl),
        .osc_tick(osc_tick)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.rdata = '0;
        idx = reg_addr[ADDR_W-1:LANE_W];
        hit = (reg_addr[LANE_W-1:0] == LANE_ZERO);

        // register writes
        if (reg_write && hit) begin
            unique case (idx)
                IDX_ENABLE: begin
                    d.loop_enable = reg_wdata[LOOP_ENABLE_BIT];
                    d.oscillator_enable = reg_wdata[OSC_ENABLE_BIT];
                    d.fractional_mode = reg_wdata[FRACTIONAL_BIT];
                end
                IDX_DIVIDER: begin
                    d.output_divider =
                        reg_wdata[OUTDIV_LSB +: OUTDIV_W];
                    d.feedback_ratio =
                        reg_wdata[FRATIO_LSB +: FRATIO_W];
                end
                IDX_FRACTION: begin
                    d.fraction_multiplier = reg_wdata;
                end
                IDX_INTEGER: begin
                    d.integer_multiplier =
                        reg_wdata[INTMUL_LSB +: INTMUL_W];
                end
                IDX_REFERENCE: begin
                    d.forced_oscillator_value =
                        reg_wdata[FORCE_VAL_LSB +: FORCE_VAL_W];
                    d.force_oscillator_select =
                        reg_wdata[FORCE_SEL_BIT];
                    d.reference_divider =
                        reg_wdata[REFDIV_LSB +: REFDIV_W];
                    d.reference_source_select =
                        reg_wdata[SRC_LSB +: SRC_W];
                end
                default: begin
                end
            endcase
        end

        // register reads, unmapped addresses read zero
        if (reg_read && hit) begin
            unique case (idx)
                IDX_ENABLE: begin
                    d.rdata[LOOP_ENABLE_BIT] = q.loop_enable;
                    d.rdata[OSC_ENABLE_BIT] = q.oscillator_enable;
                    d.rdata[FRACTIONAL_BIT] = q.fractional_mode;
                end
                IDX_DIVIDER: begin
                    d.rdata[OUTDIV_LSB +: OUTDIV_W] = q.output_divider;
                    d.rdata[FRATIO_LSB +: FRATIO_W] = q.feedback_ratio;
                end
                IDX_FRACTION: begin
                    d.rdata = q.fraction_multiplier;
                end
                IDX_INTEGER: begin
                    d.rdata[INTMUL_LSB +: INTMUL_W] =
                        q.integer_multiplier;
                end
                IDX_REFERENCE: begin
                    d.rdata[FORCE_VAL_LSB +: FORCE_VAL_W] =
                        q.forced_oscillator_value;
                    d.rdata[FORCE_SEL_BIT] = q.force_oscillator_select;
                    d.rdata[REFDIV_LSB +: REFDIV_W] = q.reference_divider;
                    d.rdata[SRC_LSB +: SRC_W] = q.reference_source_select;
                end
                IDX_STATUS: begin
                    d.rdata[STAT_RUN_BIT] = q.running;
                    d.rdata[STAT_LOCK_BIT] = q.locked;
                    d.rdata[STAT_FREE_BIT] = (q.mode == FLLC_FREE);
                end
                default: begin
                end
            endcase
        end

        // [RULE_01] run only with loop enable set
        if (!q.loop_enable) begin
            d.mode = FLLC_OFF;
        end else if (q.force_oscillator_select) begin
            d.mode = q.oscillator_enable ? FLLC_FREE : FLLC_OFF;
        end else begin
            d.mode = FLLC_TRACK;
        end

        // [RULE_04] feedback ratio mask
        unique case (q.feedback_ratio)
            3'h0: fb_mask = 4'h0;
            3'h1: fb_mask = 4'h1;
            3'h2: fb_mask = 4'h3;
            3'h3: fb_mask = 4'h7;
            default: fb_mask = 4'hF;
        endcase
        fb_tick = osc_tick && ((q.fb_div & fb_mask) == fb_mask);

        // [RULE_05] fraction accumulates, msb weighs one half
        frac_sum = {1'b0, q.frac_acc} + {1'b0, q.fraction_multiplier};
        // [RULE_06] integer part of the multiplier
        target = {{(REG_W-INTMUL_W){1'b0}}, q.integer_multiplier}
            + {{(REG_W-1){1'b0}}, q.fractional_mode & frac_sum[REG_W]};
        fb_total = q.fb_cnt + {{(REG_W-1){1'b0}}, fb_tick};
        ctl_up = {1'b0, q.ctl} + {1'b0, LOOP_STEP};

        // [RULE_03] half period of the output divider
        out_half = OUT_CNT_W'((8'h01 << q.output_divider) - 8'h01);

        unique case (q.mode)
            FLLC_OFF: begin
                d.ctl = '0;
                d.fb_div = '0;
                d.fb_cnt = '0;
                d.frac_acc = '0;
                d.locked = 1'b0;
            end
            FLLC_FREE: begin
                // [RULE_07] forced value drives oscillator
                // [RULE_08] forced value placed at the top
                d.ctl = {q.forced_oscillator_value,
                         {(CTL_W-FORCE_VAL_W){1'b0}}};
                d.locked = 1'b0;
            end
            FLLC_TRACK: begin
                // [RULE_07] digital loop steers oscillator
                if (osc_tick) begin
                    d.fb_div = q.fb_div + 4'h1;
                end
                if (ref_tick) begin
                    d.fb_cnt = '0;
                    if (q.fractional_mode) begin
                        d.frac_acc = frac_sum[REG_W-1:0];
                    end
                    d.locked = (fb_total == target);
                    if (fb_total < target) begin
                        d.ctl = ctl_up[CTL_W] ? '1 : ctl_up[CTL_W-1:0];
                    end else if (fb_total > target) begin
                        d.ctl = (q.ctl < LOOP_STEP) ? '0
                            : q.ctl - LOOP_STEP;
                    end
                end else if (fb_tick && (q.fb_cnt != '1)) begin
                    d.fb_cnt = fb_total;
                end
            end
            default: begin
                d.mode = FLLC_OFF;
            end
        endcase

        // [RULE_03] output clock divider
        if (q.mode == FLLC_OFF) begin
            d.out_cnt = '0;
            d.out_clk = 1'b0;
        end else if (osc_tick) begin
            if (q.out_cnt >= out_half) begin
                d.out_cnt = '0;
                d.out_clk = !q.out_clk;
            end else begin
                d.out_cnt = q.out_cnt + 7'h01;
            end
        end
        d.running = (q.mode != FLLC_OFF);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.mode <= FLLC_OFF;
            q.integer_multiplier <= INTMUL_RESET;
            // [RULE_11] bit clock at reset
            q.reference_source_select <= SRC_RESET;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign loop_output_clk = q.out_clk;
    assign loop_running = q.running;
    assign loop_locked = q.locked;

endmodule : fllc_control

// >>> testbench/fllc_control_assertions.sv
// port-level checks for the loop clock generator control
`timescale 1ns/10ps
module fllc_control_assertions
    import fllc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [REG_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [REG_W-1:0] reg_rdata,
    input wire logic loop_output_clk,
    input wire logic loop_running,
    input wire logic loop_locked
);
    // ----------
    // shadows of written registers
    // ----------
    logic [2:0] en_q;
    logic [REG_W-1:0] int_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            en_q <= 3'h0;
            int_q <= 16'h2EE0;
        end else if (reg_write && reg_addr == 10'h0F0) begin
            en_q <= reg_wdata[2:0];
        end else if (reg_write && reg_addr == 10'h0FC) begin
            int_q <= reg_wdata & 16'h7FE0;
        end
    end

    // ----------
    // properties
    // ----------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence run_on_s;
        reg_write && reg_addr == 10'h0F0 && reg_wdata[1:0] == 2'h3;
    endsequence
    sequence run_off_s;
        reg_write && reg_addr == 10'h0F0 && !reg_wdata[0];
    endsequence

    rdata_idle_a:
        assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
        else $error("read data outside its slot");
    misalign_read_a:
        assert property (reg_read && reg_addr[1:0] != 2'h0
            |=> reg_rdata == 16'h0000)
        else $error("misaligned read not zero");
    en_readback_a:
        assert property (reg_read && reg_addr == 10'h0F0
            |=> reg_rdata == {13'h0000, $past(en_q)})
        else $error("enable register readback wrong");
    int_readback_a:
        assert property (reg_read && reg_addr == 10'h0FC
            |=> reg_rdata == $past(int_q))
        else $error("integer multiplier readback wrong");
    run_start_a:
        assert property (run_on_s |-> ##[2:3] loop_running)
        else $error("loop did not start");
    run_stop_a:
        assert property (run_off_s |-> ##[2:3] !loop_running)
        else $error("loop did not stop");
    status_run_a:
        assert property (reg_read && reg_addr == 10'h140
            |=> reg_rdata[0] == $past(loop_running) || $changed(loop_running))
        else $error("status running bit wrong");
    clk_quiet_a:
        assert property (!loop_running [*4] |=> $stable(loop_output_clk))
        else $error("output clock moves while stopped");
endmodule : fllc_control_assertions

bind fllc_control fllc_control_assertions u_fllc_control_assertions (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .loop_output_clk(loop_output_clk),
    .loop_running(loop_running), .loop_locked(loop_locked));

// >>> testbench/fllc_ref_model.sv
// free-running reference clocks: master 8, bit 16, frame 64 cycles
`timescale 1ns/10ps
module fllc_ref_model
    import fllc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    output logic master_clk_in,
    output logic frame_clk_in,
    output logic bit_clk_in
);
    logic [7:0] cnt_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    assign master_clk_in = cnt_q[2];
    assign bit_clk_in = cnt_q[3];
    assign frame_clk_in = cnt_q[5];
endmodule : fllc_ref_model

// >>> testbench/fllc_control_tb_top.sv
// self-checking bench for the loop clock generator control
`timescale 1ns/10ps
module fllc_control_tb_top
    import fllc_pkg::*;
;
    // ----------
    // signals and tables
    // ----------
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = 10'h000;
    logic [REG_W-1:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [REG_W-1:0] reg_rdata;
    logic master_clk_in;
    logic frame_clk_in;
    logic bit_clk_in;
    logic loop_output_clk;
    logic loop_running;
    logic loop_locked;
    int fails = 0;
    int total_checks = 0;
    bit locked_seen = 1'b0;
    logic [ADDR_W-1:0] ra [5] = '{10'h0F0, 10'h0F4, 10'h0F8, 10'h0FC,
        10'h100};
    logic [REG_W-1:0] rv [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h2EE0,
        16'h0002};
    logic [REG_W-1:0] rm [5] = '{16'h0007, 16'h0707, 16'hFFFF, 16'h7FE0,
        16'h1FDB};
    // source, ref divider, integer, ratio code, fraction, enable word
    int tc [6][6] = '{'{0, 0, 3, 0, 0, 5}, '{0, 1, 2, 1, 0, 5},
        '{1, 0, 1, 5, 0, 5}, '{2, 3, 4, 3, 0, 5},
        '{0, 0, 2, 0, 32768, 5}, '{0, 0, 2, 0, 32768, 1}};
    int per [3] = '{8, 64, 16};

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    fllc_ref_model u_fllc_ref_model (
        .sys_clk(sys_clk), .rst(rst), .master_clk_in(master_clk_in),
        .frame_clk_in(frame_clk_in), .bit_clk_in(bit_clk_in));

    fllc_control #(.LOOP_STEP(16'h0400)) u_fllc_control (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .master_clk_in(master_clk_in),
        .frame_clk_in(frame_clk_in), .bit_clk_in(bit_clk_in),
        .loop_output_clk(loop_output_clk), .loop_running(loop_running),
        .loop_locked(loop_locked));

    // ----------
    // tasks
    // ----------
    task automatic check(input logic [REG_W-1:0] got, input logic [REG_W-1:0] e);
        total_checks++;
        if (got !== e) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, e);
        end
    endtask : check

    task automatic near(input int got, input int e, input int tol);
        total_checks++;
        if (got < e - tol || got > e + tol) begin
            fails++;
            $display("BAD %0t count %0d exp %0d", $time, got, e);
        end
    endtask : near

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e,
        input logic [REG_W-1:0] m = 16'hFFFF);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 check(reg_rdata & m, e);
        @(posedge sys_clk);
        #1 check(reg_rdata, 16'h0000);
    endtask : rd

    task automatic run_is(input logic e);
        repeat (3) @(posedge sys_clk);
        #1 check({15'h0000, loop_running}, {15'h0000, e});
    endtask : run_is

    task automatic measure(input int n, output int t);
        logic p;
        t = 0;
        p = loop_output_clk;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            if (loop_output_clk !== p) t++;
            if (loop_locked === 1'b1) locked_seen = 1'b1;
            p = loop_output_clk;
        end
    endtask : measure

    task automatic stop_test();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (90000) @(posedge sys_clk);
        fails++;
        stop_test();
    end

    // ----------
    // test sequence
    // ----------
    initial begin
        int t;
        int f;
        int d;
        int fv;
        int k;
        real x;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(ra[i], rv[i]);
            wr(ra[i], 16'hFFFF);
            rd(ra[i], rm[i]);
            wr(ra[i], rv[i]);
        end
        wr(10'h0F2, 16'h0001);
        rd(10'h0F0, 16'h0000);
        rd(10'h0F2, 16'h0000);
        wr(10'h140, 16'hFFFF);
        rd(10'h140, 16'h0000);
        rd(10'h200, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            f = tc[i][3] > 3 ? 16 : 1 << tc[i][3];
            d = 1 << tc[i][1];
            x = tc[i][2] + ((tc[i][5] & 4) != 0 ? tc[i][4] / 65536.0 : 0.0);
            wr(10'h0F0, 16'h0000);
            wr(10'h0F4, 16'(tc[i][3]));
            wr(10'h0F8, 16'(tc[i][4]));
            wr(10'h0FC, 16'(tc[i][2] << 5));
            wr(10'h100, 16'(tc[i][1] * 8 + tc[i][0]));
            wr(10'h0F0, 16'(tc[i][5]));
            run_is(1'b1);
            repeat (3072) @(posedge sys_clk);
            measure(4096, t);
            x = 4096.0 * x * f / (per[tc[i][0]] * d);
            near(t, int'(x), int'(x) / 8);
        end
        check({15'h0000, locked_seen}, 16'h0001);
        for (int i = 0; i < 10; i++) begin
            fv = i < 8 ? 25 : (i == 8 ? 63 : 0);
            k = i < 8 ? i : 0;
            wr(10'h0F0, 16'h0000);
            wr(10'h0F4, 16'(k << 8));
            wr(10'h100, 16'(fv * 128) | 16'h0042);
            wr(10'h0F0, 16'h0003);
            run_is(1'b1);
            measure(2048, t);
            near(t, (fv * 32) >> k, 2);
        end
        rd(10'h140, 16'h0005, 16'h0005);
        wr(10'h0F0, 16'h0001);
        run_is(1'b0);
        wr(10'h0F0, 16'h0000);
        rd(10'h140, 16'h0000);
        stop_test();
    end
endmodule : fllc_control_tb_top
